// ==== pkg/srct_pkg.sv ====
// constants, offsets and types for the stream record class tracker
`default_nettype none
package srct_pkg;
    // bus widths
    localparam int unsigned LBA_W = 32;
    localparam int unsigned TAG_W = 16;
    localparam int unsigned NLB_W = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    // register byte offsets
    localparam logic [7:0] REG_STATUS    = 8'h00;
    localparam logic [7:0] REG_WRITE_UNIT = 8'h04;
    localparam logic [7:0] REG_GRANULE   = 8'h08;
    localparam logic [7:0] REG_MAX_OPEN  = 8'h0C;
    localparam logic [7:0] REG_MAX_XFER  = 8'h10;
    localparam logic [7:0] REG_RESOURCES = 8'h14;
    localparam logic [7:0] REG_LOG_SEL   = 8'h18;
    localparam logic [7:0] REG_LOG_DATA  = 8'h1C;
    localparam logic [7:0] REG_LOG_COUNT = 8'h20;
    // status field positions in the status register
    localparam int unsigned ST_STATE_LSB = 0;
    localparam int unsigned ST_COUNT_LSB = 8;
    // completion status values
    localparam logic [7:0] CPL_OK       = 8'h00;
    localparam logic [7:0] CPL_CONFLICT = 8'h80;
    // reset values
    localparam logic [15:0] RESOURCES_RST = 16'h0000;
    localparam logic [7:0]  LOG_SEL_RST   = 8'h00;
    // permitted granule sizes in megabytes and open stream limits
    localparam int unsigned GRANULE_MIN_MB = 120;
    localparam int unsigned GRANULE_MAX_MB = 4080;
    localparam int unsigned PARALLEL_MAX   = 8;
    localparam int unsigned OPEN_MIN       = 2;
    // host command codes
    typedef enum logic [2:0] {
        SRCT_ALLOCATE,
        SRCT_RELEASE_RES,
        SRCT_RELEASE_ID,
        SRCT_START_REC,
        SRCT_SEQ_WRITE,
        SRCT_SUSPEND,
        SRCT_RESUME,
        SRCT_OTHER
    } srct_cmd_t;
    // tracker states
    typedef enum logic [1:0] {
        SRCT_NORMAL,
        SRCT_READY,
        SRCT_RECORDING
    } srct_state_t;
endpackage : srct_pkg
`default_nettype wire

// ==== tb/srct_host_model.sv ====
// host controller model driving the tracker command port
`default_nettype none
module srct_host_model (
    // clock
    input  wire logic                      clock,
    // command port toward the tracker
    output var logic                       cmd_valid,
    output var srct_pkg::srct_cmd_t        cmd_code,
    output var logic                       cmd_first,
    output var logic                       cmd_last,
    output var logic [srct_pkg::TAG_W-1:0] cmd_tag,
    output var logic [srct_pkg::LBA_W-1:0] cmd_lba,
    output var logic [srct_pkg::NLB_W-1:0] cmd_nlb,
    output var logic [7:0]                 cmd_resources,
    // completion from the tracker
    input  wire logic                      cpl_valid,
    input  wire logic [7:0]                cpl_status
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle port at time zero
    initial
    begin
        cmd_valid = 1'b0;
        cmd_code = srct_pkg::SRCT_OTHER;
        cmd_first = 1'b0;
        cmd_last = 1'b0;
        cmd_tag = 16'h0000;
        cmd_lba = 32'h0000_0000;
        cmd_nlb = 16'h0000;
        cmd_resources = 8'h00;
    end
    // one entry held to its taking edge
    task automatic send(input srct_pkg::srct_cmd_t code,
        input logic f, input logic l, input logic [15:0] tag,
        input logic [31:0] lba, input logic [15:0] nlb,
        output logic seen, output logic [7:0] st);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        cmd_first <= f;
        cmd_last <= l;
        cmd_tag <= tag;
        cmd_lba <= lba;
        cmd_nlb <= nlb;
        cmd_resources <= nlb[7:0];
        @(posedge clock);
        cmd_valid <= 1'b0;
        // released qualifiers show the inverse
        cmd_tag <= ~tag;
        cmd_lba <= ~lba;
        cmd_nlb <= ~nlb;
        cmd_resources <= ~nlb[7:0];
        #1;
        seen = cpl_valid;
        st = cpl_status;
    endtask : send
endmodule : srct_host_model
`default_nettype wire

// ==== tb/srct_tracker_sva.sv ====
// assertion checker for the stream record class tracker
`default_nettype none
module srct_tracker_sva #(
    parameter int unsigned WU_MB         = 4,
    parameter int unsigned GRANULE_WU    = 30,
    parameter int unsigned BLOCKS_PER_MB = 128
) (
    // clock and reset
    input wire logic                        clock,
    input wire logic                        rst_b,
    // command, completion and guarantees
    input wire logic                        cmd_valid,
    input wire srct_pkg::srct_cmd_t         cmd_code,
    input wire logic                        multi_queue,
    input wire logic                        cpl_valid,
    input wire logic [7:0]                  cpl_status,
    input wire logic                        write_guaranteed,
    input wire logic                        read_guaranteed,
    // register port
    input wire logic [srct_pkg::ADDR_W-1:0] reg_addr,
    input wire logic                        reg_rd,
    input wire logic [srct_pkg::DATA_W-1:0] reg_rdata
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    // completion pulse tied to each command
    AST_CPL_ONE: assert property (cmd_valid |=> cpl_valid)
        else $error("completion missing after command");
    AST_CPL_NONE: assert property (!cmd_valid |=> !cpl_valid)
        else $error("completion without command");
    // only a suspend may be refused
    AST_CPL_OK: assert property (cmd_valid &&
        cmd_code != srct_pkg::SRCT_SUSPEND |=> cpl_status == srct_pkg::CPL_OK)
        else $error("non-suspend command refused");
    // published stream parameters
    AST_WU_SIZE: assert property (reg_rd &&
        reg_addr == srct_pkg::REG_WRITE_UNIT |=>
        reg_rdata == WU_MB * BLOCKS_PER_MB)
        else $error("write unit size wrong");
    AST_GRANULE: assert property (reg_rd &&
        reg_addr == srct_pkg::REG_GRANULE |=> reg_rdata == GRANULE_WU)
        else $error("granule size wrong");
    AST_MAX_OPEN: assert property (reg_rd &&
        reg_addr == srct_pkg::REG_MAX_OPEN |=>
        reg_rdata >= srct_pkg::OPEN_MIN)
        else $error("max open streams below two");
    AST_MAX_XFER: assert property (reg_rd &&
        reg_addr == srct_pkg::REG_MAX_XFER |=>
        reg_rdata >= WU_MB * BLOCKS_PER_MB)
        else $error("max transfer below write unit");
    // read data stands only after a read
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data outside read answer");
    // extra queues drop every guarantee
    AST_MQ_DROP: assert property (multi_queue |=>
        !read_guaranteed && !write_guaranteed)
        else $error("guarantee kept with several queues");
    AST_WR_RD: assert property (write_guaranteed |-> read_guaranteed)
        else $error("write guarantee without read guarantee");
    AST_REL_RES: assert property (cmd_valid &&
        cmd_code == srct_pkg::SRCT_RELEASE_RES |=> ##1 !read_guaranteed [*2])
        else $error("guarantee kept after resource release");
    // main scenarios
    COV_REJECT: cover property (cpl_valid &&
        cpl_status == srct_pkg::CPL_CONFLICT);
    COV_RECORD: cover property ($rose(write_guaranteed));
    COV_RESUME: cover property (cmd_valid &&
        cmd_code == srct_pkg::SRCT_RESUME);
endmodule : srct_tracker_sva
bind srct_tracker srct_tracker_sva #(
    .WU_MB(WU_MB),
    .GRANULE_WU(GRANULE_WU),
    .BLOCKS_PER_MB(BLOCKS_PER_MB)
) u_sva (
    .clock(clock), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .multi_queue(multi_queue), .cpl_valid(cpl_valid),
    .cpl_status(cpl_status), .write_guaranteed(write_guaranteed),
    .read_guaranteed(read_guaranteed), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking testbench for the stream record class tracker
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] WU = 32'h0000_0200;
    localparam logic [31:0] GB = 30 * WU;
    localparam logic [31:0] A1 = 4 * GB;
    localparam logic [31:0] A2 = 8 * GB;
    // bench inputs and design outputs
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        multi_queue = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        cmd_valid, cmd_first, cmd_last, cpl_valid;
    logic        write_guaranteed, read_guaranteed;
    logic [15:0] cmd_tag, cmd_nlb;
    logic [31:0] cmd_lba;
    logic [7:0]  cmd_resources, cpl_status;
    srct_pkg::srct_cmd_t cmd_code;
    int          fail_count = 0;
    int          checks_done = 0;
    // host model on the command port
    srct_host_model u_host (.clock(clock), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_first(cmd_first), .cmd_last(cmd_last),
        .cmd_tag(cmd_tag), .cmd_lba(cmd_lba), .cmd_nlb(cmd_nlb),
        .cmd_resources(cmd_resources), .cpl_valid(cpl_valid),
        .cpl_status(cpl_status));
    srct_tracker dut (
        .clock(clock), .rst_b(rst_b), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_first(cmd_first), .cmd_last(cmd_last),
        .cmd_tag(cmd_tag), .cmd_lba(cmd_lba), .cmd_nlb(cmd_nlb),
        .cmd_resources(cmd_resources), .multi_queue(multi_queue),
        .cpl_valid(cpl_valid), .cpl_status(cpl_status),
        .write_guaranteed(write_guaranteed),
        .read_guaranteed(read_guaranteed), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    // 20 MHz clock
    initial
    begin
        forever #25 clock = ~clock;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic stat(input int cnt, input int st);
        rd(srct_pkg::REG_STATUS, 32'(cnt * 256 + st));
    endtask : stat
    // one command entry and its completion judged
    task automatic cmd(input srct_pkg::srct_cmd_t c, input logic f,
        input logic l, input logic [15:0] t, input logic [31:0] a,
        input logic [15:0] n, input logic [7:0] exp = 8'h00);
        logic       v;
        logic [7:0] s;
        u_host.send(c, f, l, t, a, n, v, s);
        chk(v, 1'b1);
        chk(s, exp);
    endtask : cmd
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task automatic t_reset();
        stat(0, 0);
        chk(read_guaranteed, 1'b0);
        wr(srct_pkg::REG_WRITE_UNIT, 32'h0000_0000);
        rd(srct_pkg::REG_WRITE_UNIT, WU);
        rd(srct_pkg::REG_GRANULE, 32'h0000_001E);
        rd(srct_pkg::REG_MAX_OPEN, 32'h0000_0008);
        rd(srct_pkg::REG_MAX_XFER, WU);
        rd(srct_pkg::REG_RESOURCES, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_alloc();
        cmd(srct_pkg::SRCT_ALLOCATE, 1, 1, 0, 0, 3);
        stat(0, 1);
        chk(read_guaranteed, 1'b1);
        chk(write_guaranteed, 1'b0);
        $display("test allocate done");
    endtask : t_alloc
    task automatic t_open();
        cmd(srct_pkg::SRCT_START_REC, 1, 0, 0, A1, 0);
        cmd(srct_pkg::SRCT_START_REC, 0, 1, 0, A2, 0);
        cmd(srct_pkg::SRCT_SEQ_WRITE, 1, 1, 5, 12 * GB, WU[15:0]);
        stat(0, 1);
        cmd(srct_pkg::SRCT_SEQ_WRITE, 1, 1, 1, A1, WU[15:0]);
        stat(1, 2);
        chk(write_guaranteed, 1'b1);
        cmd(srct_pkg::SRCT_SEQ_WRITE, 1, 1, 2, A2, 16'h0400);
        stat(2, 2);
        cmd(srct_pkg::SRCT_ALLOCATE, 1, 1, 0, 0, 2);
        stat(2, 2);
        rd(srct_pkg::REG_RESOURCES, 32'h0000_0005);
        $display("test open done");
    endtask : t_open
    task automatic t_suspend();
        cmd(srct_pkg::SRCT_SUSPEND, 1, 0, 0, A1 + WU, 0);
        cmd(srct_pkg::SRCT_SUSPEND, 0, 1, 0, A2 + WU, 0, 8'h80);
        rd(srct_pkg::REG_LOG_COUNT, 32'h0000_0000);
        for (int i = 1; i < 30; i++)
            cmd(srct_pkg::SRCT_SEQ_WRITE, 1, 1, 1, A1 + i * WU, WU[15:0]);
        cmd(srct_pkg::SRCT_SUSPEND, 1, 1, 0, A1 + GB, 0, 8'h80);
        cmd(srct_pkg::SRCT_SUSPEND, 1, 1, 0, A2 + 2 * WU, 0);
        rd(srct_pkg::REG_LOG_COUNT, 32'h0000_0001);
        wr(srct_pkg::REG_LOG_SEL, 32'h0000_0000);
        rd(srct_pkg::REG_LOG_DATA, A2 + 2 * WU);
        stat(2, 2);
        $display("test suspend done");
    endtask : t_suspend
    task automatic t_release();
        cmd(srct_pkg::SRCT_RELEASE_ID, 1, 1, 9, 0, 0);
        stat(2, 2);
        cmd(srct_pkg::SRCT_RELEASE_ID, 1, 1, 1, 0, 0);
        stat(1, 2);
        cmd(srct_pkg::SRCT_RELEASE_ID, 1, 1, 2, 0, 0);
        stat(0, 1);
        cmd(srct_pkg::SRCT_RELEASE_ID, 1, 1, 2, 0, 0);
        stat(0, 1);
        $display("test release done");
    endtask : t_release
    task automatic t_resume();
        cmd(srct_pkg::SRCT_RESUME, 1, 1, 0, A2 + 2 * WU, 0);
        cmd(srct_pkg::SRCT_SEQ_WRITE, 1, 1, 4, A2 + 2 * WU, WU[15:0]);
        stat(1, 2);
        @(posedge clock);
        multi_queue <= 1'b1;
        @(posedge clock);
        #1;
        chk({read_guaranteed, write_guaranteed}, 2'b00);
        @(posedge clock);
        multi_queue <= 1'b0;
        @(posedge clock);
        #1;
        chk({read_guaranteed, write_guaranteed}, 2'b11);
        cmd(srct_pkg::SRCT_RELEASE_RES, 1, 1, 0, 0, 0);
        stat(0, 0);
        rd(srct_pkg::REG_RESOURCES, 32'h0000_0000);
        chk(read_guaranteed, 1'b0);
        $display("test resume done");
    endtask : t_resume
    // hang guard
    initial
    begin
        #250000;
        fail_count++;
        finish_test();
    end
    // main sequence
    initial
    begin
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        t_reset();
        t_alloc();
        t_open();
        t_suspend();
        t_release();
        t_resume();
        finish_test();
    end
endmodule : tb
`default_nettype wire

// ==== verilog/srct_tracker.sv ====
// stream record class state tracker with parameter and status registers
//
// The implementer's own choices: the address map and the plain strobed port.
`default_nettype none
// Contract
// - after link-up the tracker sits in normal access.
// - allocate-resources moves to ready.
// - first write at a listed address opens the tag and enters recording.
// - first write at an unlisted address opens nothing.
// - further allocations add resources without changing state.
// - release-identifier of an open tag drops it and decrements count.
// - count reaching zero returns recording to ready.
// - release-resources drops all tags and goes to normal.
// - one queue in ready/recording; extra queues only drop guarantees.
// - read throughput guaranteed only in ready and recording.
// - write unit reported as 4, 5 or 6 MB.
// - granule reported in write units, 120 to 4080 MB.
// - granule is a multiple of the cluster size.
// - max open streams at least 2; at most 8 guaranteed.
// - max transfer size not below write unit.
// - valid suspend address is last write start plus length.
// - bad suspend address or granule boundary rejects with 80h, log kept.
module srct_tracker #(
    parameter int unsigned WU_MB         = 4,
    parameter int unsigned GRANULE_WU    = 30,
    parameter int unsigned CLUSTER_MB    = 8,
    parameter int unsigned MAX_OPEN      = 8,
    parameter int unsigned MAX_XFER_MB   = 4,
    parameter int unsigned BLOCKS_PER_MB = 128
) (
    // clock and reset
    input  wire logic                           clock,
    input  wire logic                           rst_b,
    // host command port
    input  wire logic                           cmd_valid,
    input  wire srct_pkg::srct_cmd_t            cmd_code,
    input  wire logic                           cmd_first,
    input  wire logic                           cmd_last,
    input  wire logic [srct_pkg::TAG_W-1:0]     cmd_tag,
    input  wire logic [srct_pkg::LBA_W-1:0]     cmd_lba,
    input  wire logic [srct_pkg::NLB_W-1:0]     cmd_nlb,
    input  wire logic [7:0]                     cmd_resources,
    input  wire logic                           multi_queue,
    // completion
    output logic                                cpl_valid,
    output logic [7:0]                          cpl_status,
    // guarantees
    output logic                                write_guaranteed,
    output logic                                read_guaranteed,
    // register port
    input  wire logic [srct_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [srct_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic [srct_pkg::DATA_W-1:0]         reg_rdata
);
    localparam int unsigned CNT_W = $clog2(MAX_OPEN + 1);
    localparam int unsigned IDX_W = (MAX_OPEN > 1) ? $clog2(MAX_OPEN) : 1;
    localparam logic [31:0] WU_BLK = 32'(WU_MB * BLOCKS_PER_MB);
    localparam logic [31:0] GR_BLK = 32'(GRANULE_WU) * WU_BLK;
    localparam int unsigned GR_MB  = GRANULE_WU * WU_MB;

    // elaboration check of reported parameters
    // write unit set
    if (WU_MB < 4 || WU_MB > 6)
        $error("write unit must be 4, 5 or 6 MB");
    if (GR_MB < srct_pkg::GRANULE_MIN_MB ||
        GR_MB > srct_pkg::GRANULE_MAX_MB)
        $error("granule size out of range");
    if (CLUSTER_MB == 0 || (GR_MB % CLUSTER_MB) != 0)
        $error("granule not a multiple of cluster");
    if (MAX_OPEN < srct_pkg::OPEN_MIN ||
        MAX_OPEN > srct_pkg::PARALLEL_MAX)
        $error("max open streams must be 2 to 8");
    if (MAX_XFER_MB < WU_MB)
        $error("max transfer below write unit");

    srct_pkg::srct_state_t              state_q;
    logic [CNT_W-1:0]                   open_count_q;
    logic [MAX_OPEN-1:0]                slot_v_q;
    logic [srct_pkg::TAG_W-1:0]         slot_tag_q [MAX_OPEN];
    logic [srct_pkg::LBA_W-1:0]         slot_end_q [MAX_OPEN];
    logic [MAX_OPEN-1:0]                list_v_q;
    logic [srct_pkg::LBA_W-1:0]         list_a_q   [MAX_OPEN];
    logic [srct_pkg::LBA_W-1:0]         pend_a_q   [MAX_OPEN];
    logic [CNT_W-1:0]                   pend_n_q;
    logic                               pend_bad_q;
    logic [srct_pkg::LBA_W-1:0]         log_a_q    [MAX_OPEN];
    logic [CNT_W-1:0]                   log_n_q;
    logic [15:0]                        resources_q;
    logic [7:0]                         log_sel_q;

    // command decode
    logic is_wr;
    logic is_rel_id;
    logic is_list;
    logic is_susp;
    logic is_rel;
    assign is_wr     = cmd_valid && cmd_code == srct_pkg::SRCT_SEQ_WRITE;
    assign is_rel_id = cmd_valid && cmd_code == srct_pkg::SRCT_RELEASE_ID;
    assign is_list   = cmd_valid && state_q != srct_pkg::SRCT_NORMAL &&
                       (cmd_code == srct_pkg::SRCT_START_REC ||
                        cmd_code == srct_pkg::SRCT_RESUME);
    assign is_susp   = cmd_valid && cmd_code == srct_pkg::SRCT_SUSPEND;
    assign is_rel    = cmd_valid && cmd_code == srct_pkg::SRCT_RELEASE_RES;

    // tag, free slot, list and suspend point lookup
    logic             tag_hit;
    logic [IDX_W-1:0] tag_idx;
    logic             free_hit;
    logic [IDX_W-1:0] free_idx;
    logic             list_hit;
    logic [IDX_W-1:0] list_idx;
    logic             end_hit;
    logic             list_room;
    logic [IDX_W-1:0] list_free;
    always_comb
    begin
        tag_hit   = 1'b0;
        tag_idx   = '0;
        free_hit  = 1'b0;
        free_idx  = '0;
        list_hit  = 1'b0;
        list_idx  = '0;
        end_hit   = 1'b0;
        list_room = 1'b0;
        list_free = '0;
        for (int i = MAX_OPEN - 1; i >= 0; i--)
        begin
            if (slot_v_q[i] && slot_tag_q[i] == cmd_tag)
            begin
                tag_hit = 1'b1;
                tag_idx = IDX_W'(i);
            end
            if (!slot_v_q[i])
            begin
                free_hit = 1'b1;
                free_idx = IDX_W'(i);
            end
            if (list_v_q[i] && list_a_q[i] == cmd_lba)
            begin
                list_hit = 1'b1;
                list_idx = IDX_W'(i);
            end
            if (slot_v_q[i] && slot_end_q[i] == cmd_lba)
                end_hit = 1'b1;
            if (!list_v_q[i])
            begin
                list_room = 1'b1;
                list_free = IDX_W'(i);
            end
        end
    end

    // first write at listed address opens a tag
    logic opening;
    assign opening = is_wr && state_q != srct_pkg::SRCT_NORMAL &&
                     !tag_hit && list_hit && free_hit;
    // release of an open tag, others ignored
    logic closing;
    assign closing = is_rel_id && tag_hit;

    // suspend address check, write unit alignment
    logic susp_ok;
    assign susp_ok = end_hit && (cmd_lba % GR_BLK) != 32'h0000_0000 &&
                     (cmd_lba % WU_BLK) == 32'h0000_0000;

    // state machine
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            state_q <= srct_pkg::SRCT_NORMAL;
        else if (cmd_valid)
        begin
            unique case (cmd_code)
                srct_pkg::SRCT_ALLOCATE:
                    if (state_q == srct_pkg::SRCT_NORMAL)
                        state_q <= srct_pkg::SRCT_READY;
                srct_pkg::SRCT_RELEASE_RES:
                    state_q <= srct_pkg::SRCT_NORMAL;
                srct_pkg::SRCT_RELEASE_ID:
                    if (closing && open_count_q == CNT_W'(1))
                        state_q <= srct_pkg::SRCT_READY;
                srct_pkg::SRCT_SEQ_WRITE:
                    if (opening)
                        state_q <= srct_pkg::SRCT_RECORDING;
                default:
                    state_q <= state_q;
            endcase
        end
    end

    // open stream count
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            open_count_q <= '0;
        else if (is_rel)
            open_count_q <= '0;
        else if (opening)
            open_count_q <= open_count_q + CNT_W'(1);
        else if (closing)
            open_count_q <= open_count_q - CNT_W'(1);
    end

    // open tag slots and the end of each tag's last write
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            slot_v_q <= '0;
        else if (is_rel)
            slot_v_q <= '0;
        else if (opening)
            slot_v_q[free_idx] <= 1'b1;
        else if (closing)
            slot_v_q[tag_idx] <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (opening)
        begin
            slot_tag_q[free_idx] <= cmd_tag;
            slot_end_q[free_idx] <= cmd_lba + srct_pkg::LBA_W'(cmd_nlb);
        end
        else if (is_wr && tag_hit)
            slot_end_q[tag_idx] <= cmd_lba + srct_pkg::LBA_W'(cmd_nlb);
    end

    // unlisted first write leaves the list untouched
    // resume and start-recording both load listed addresses
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            list_v_q <= '0;
        else if (is_rel)
            list_v_q <= '0;
        else if (is_list && cmd_first)
        begin
            list_v_q    <= '0;
            list_v_q[0] <= 1'b1;
        end
        else if (is_list && list_room)
            list_v_q[list_free] <= 1'b1;
        // each listed address opens one tag
        else if (opening)
            list_v_q[list_idx] <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (is_list && cmd_first)
            list_a_q[0] <= cmd_lba;
        else if (is_list && list_room)
            list_a_q[list_free] <= cmd_lba;
    end

    // suspend staging, committed only if all pass
    logic [CNT_W-1:0] pend_base;
    logic             pend_bad;
    logic             susp_accept;
    assign pend_base   = cmd_first ? '0 : pend_n_q;
    assign pend_bad    = (cmd_first ? 1'b0 : pend_bad_q) || !susp_ok ||
                         pend_base == CNT_W'(MAX_OPEN);
    assign susp_accept = is_susp && cmd_last && !pend_bad;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pend_n_q   <= '0;
            pend_bad_q <= 1'b0;
        end
        else if (is_susp)
        begin
            pend_n_q   <= pend_bad ? pend_base : pend_base + CNT_W'(1);
            pend_bad_q <= pend_bad;
        end
    end

    always_ff @(posedge clock)
    begin
        if (is_susp && !pend_bad)
            pend_a_q[pend_base[IDX_W-1:0]] <= cmd_lba;
    end

    // log replaced only on accepted suspend
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            log_n_q <= '0;
        else if (susp_accept)
            log_n_q <= pend_base + CNT_W'(1);
    end

    always_ff @(posedge clock)
    begin
        if (susp_accept)
        begin
            for (int i = 0; i < MAX_OPEN; i++)
            begin
                if (CNT_W'(i) < pend_base)
                    log_a_q[i] <= pend_a_q[i];
            end
            log_a_q[pend_base[IDX_W-1:0]] <= cmd_lba;
        end
    end

    // completion for every command
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cpl_valid  <= 1'b0;
            cpl_status <= srct_pkg::CPL_OK;
        end
        else
        begin
            cpl_valid  <= cmd_valid;
            cpl_status <= (is_susp && cmd_last && pend_bad) ?
                          srct_pkg::CPL_CONFLICT : srct_pkg::CPL_OK;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            resources_q <= srct_pkg::RESOURCES_RST;
        else if (is_rel)
            resources_q <= srct_pkg::RESOURCES_RST;
        else if (cmd_valid && cmd_code == srct_pkg::SRCT_ALLOCATE)
            resources_q <= resources_q + {8'h00, cmd_resources};
    end

    // guarantees
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            write_guaranteed <= 1'b0;
            read_guaranteed  <= 1'b0;
        end
        else
        begin
            // extra queues drop guarantees without error
            write_guaranteed <= state_q == srct_pkg::SRCT_RECORDING &&
                                !multi_queue;
            read_guaranteed  <= state_q != srct_pkg::SRCT_NORMAL &&
                                !multi_queue;
        end
    end

    // log selector written by software
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            log_sel_q <= srct_pkg::LOG_SEL_RST;
        else if (reg_wr && reg_addr == srct_pkg::REG_LOG_SEL)
            log_sel_q <= reg_wdata[7:0];
    end

    // register read, data one cycle after the strobe
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                srct_pkg::REG_STATUS:
                    reg_rdata <= (32'(state_q) << srct_pkg::ST_STATE_LSB) |
                                 (32'(open_count_q) << srct_pkg::ST_COUNT_LSB);
                srct_pkg::REG_WRITE_UNIT: reg_rdata <= WU_BLK;
                srct_pkg::REG_GRANULE:   reg_rdata <= 32'(GRANULE_WU);
                srct_pkg::REG_MAX_OPEN:  reg_rdata <= 32'(MAX_OPEN);
                srct_pkg::REG_MAX_XFER:
                    reg_rdata <= 32'(MAX_XFER_MB * BLOCKS_PER_MB);
                srct_pkg::REG_RESOURCES: reg_rdata <= 32'(resources_q);
                srct_pkg::REG_LOG_SEL:   reg_rdata <= 32'(log_sel_q);
                srct_pkg::REG_LOG_DATA:
                    reg_rdata <= (32'(log_sel_q) < 32'(log_n_q)) ?
                                 log_a_q[log_sel_q[IDX_W-1:0]] : '0;
                srct_pkg::REG_LOG_COUNT: reg_rdata <= 32'(log_n_q);
                default:                 reg_rdata <= '0;
            endcase
        end
        else
            reg_rdata <= '0;
    end
endmodule : srct_tracker
`default_nettype wire
